// [src/svc_debug_pkg.sv]
// Purpose: shared constants and carriers for the service and debug block
// Assumes: 32-bit APB register bus, 22-bit control unit addresses
// Notes: register offsets are byte addresses
package svc_debug_pkg;
  typedef logic [21:0] addr_t;
  // apb register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_TLVL = 12'h008;
  localparam logic [11:0] OFF_CMP0 = 12'h00c;
  localparam logic [11:0] OFF_CMP1 = 12'h010;
  localparam logic [11:0] OFF_OPND = 12'h014;
  localparam logic [11:0] OFF_INSTR = 12'h018;
  localparam logic [11:0] OFF_TPTR = 12'h01c;
  localparam logic [5:0] TBUF_PAGE = 6'h01;
  // control bits
  localparam int C_START = 0;
  localparam int C_TRACE = 1;
  localparam int C_CMP_LOAD = 2;
  localparam int C_CMP_FETCH = 3;
  localparam int C_CMP_STOP = 4;
  localparam int C_TCLR = 5;
  localparam logic [7:0] CTRL_KEEP = 8'h1e;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // maintenance status word bits
  localparam int S_HIGH = 0;
  localparam int S_PSTOP = 1;
  localparam int S_M1 = 2;
  localparam int S_M0 = 3;
  localparam int S_BTSTOP = 5;
  localparam int S_CMPI = 6;
  localparam int S_TRACEI = 7;
  localparam logic [7:0] STAT_RST = 8'h02;
  localparam logic [7:0] STAT_W1C = 8'hfd;
  localparam logic [7:0] STAT_TRACE_FULL = 8'ha2;
  localparam logic [4:0] TLVL_RST = 5'h01;
  // external register numbers of the control unit io operations
  localparam logic [6:0] X_HIGH = 7'h70;
  localparam logic [6:0] X_LVLRST = 7'h77;
  localparam logic [6:0] X_MASK = 7'h7e;
  localparam logic [6:0] X_UNMASK = 7'h7f;
  localparam logic [2:0] START_LEVEL = 3'h1;
  localparam logic [2:0] MAX_LEVEL = 3'h5;

  typedef struct packed {
    logic io_op;
    logic io_write;
    logic [6:0] io_reg;
    addr_t io_wdata;
    logic branch;
    logic fetch;
    logic load;
    logic [2:0] level;
    addr_t iaddr;
    addr_t oaddr;
  } cu_req_s;

  typedef struct packed {
    logic stop;
    logic start;
    logic [2:0] start_level;
    addr_t io_rdata;
    logic [7:0] mask;
    logic [7:0] unmask;
    logic lvl_reset;
    logic high_irq;
    logic low_irq;
  } cu_ans_s;
endpackage : svc_debug_pkg

// [src/svc_debug.sv]
// Purpose: service and debug facilities of the central control unit
// Assumes: maintenance_processor on APB, control unit on the same clock
// Notes: trace buffer and latches freeze while the unit is stopped
// Notes on behaviour
// RQ1 - io write to x70 raises high interrupt
// RQ2 - clearing program stop starts at level 1
// RQ3 - full trace buffer stops unit, low interrupt
// RQ4 - trace any chosen set of levels 1-5
// RQ5 - trace full stop gives status word xa2
// RQ6 - compare can stop on load operand address
// RQ7 - compare hit latches operand and instruction address
// RQ8 - general registers written and read back unchanged
// RQ9 - mask x7e, unmask x7f, level reset operation
// RQ10 - two fetch compares set bits, keep last
// RQ11 - captured state stays stable while stopped
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module svc_debug
  import svc_debug_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int NGPR = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control unit side
  input wire cu_req_s cu_req,
  output cu_ans_s cu_ans
);
  localparam int PW = $clog2(DEPTH);
  localparam int GW = $clog2(NGPR);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [4:0] tlvl;
    addr_t cmp0;
    addr_t cmp1;
    addr_t opnd;
    addr_t instr;
    logic [PW:0] tptr;
    logic [DEPTH-1:0][24:0] tbuf;
    logic [NGPR-1:0][21:0] gpr;
    cu_ans_s ans;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s s_reg;
  state_s s_next;

  function automatic logic traced(input logic [2:0] lvl, input logic [4:0] sel);
    logic hit;
    hit = 1'b0;
    if (lvl >= START_LEVEL && lvl <= MAX_LEVEL) begin
      hit = sel[lvl-3'h1];
    end
    return hit;
  endfunction : traced

  function automatic logic tbuf_hit(input logic [11:0] a);
    return a[11:6] == TBUF_PAGE && a[5:2] < 4'(DEPTH);
  endfunction : tbuf_hit

  function automatic logic gpr_hit(input logic [6:0] r);
    return r < 7'(NGPR);
  endfunction : gpr_hit

  logic running;
  logic setup;
  logic wr_acc;
  logic br_take;
  logic tfull;
  logic ld_hit;
  logic f0_hit;
  logic f1_hit;
  logic io_wr;
  logic io_rd;

  assign running = !s_reg.stat[S_PSTOP];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && s_reg.pready && pwrite;
  // stalled unit records nothing, so captured state holds [RQ11]
  assign br_take = running && s_reg.ctrl[C_TRACE] && cu_req.branch
    && traced(cu_req.level, s_reg.tlvl) && s_reg.tptr < (PW+1)'(DEPTH); // [RQ3] [RQ4]
  assign tfull = br_take && s_reg.tptr == (PW+1)'(DEPTH-1);
  assign ld_hit = running && s_reg.ctrl[C_CMP_LOAD] && cu_req.load
    && cu_req.oaddr == s_reg.cmp0; // [RQ6]
  assign f0_hit = running && s_reg.ctrl[C_CMP_FETCH] && cu_req.fetch
    && cu_req.iaddr == s_reg.cmp0; // [RQ10]
  assign f1_hit = running && s_reg.ctrl[C_CMP_FETCH] && cu_req.fetch
    && cu_req.iaddr == s_reg.cmp1; // [RQ10]
  assign io_wr = running && cu_req.io_op && cu_req.io_write;
  assign io_rd = running && cu_req.io_op && !cu_req.io_write;

  always_comb begin
    s_next = s_reg;
    s_next.ans.start = 1'b0;
    s_next.ans.lvl_reset = 1'b0;
    s_next.pready = setup;
    // apb read data is prepared in the setup cycle
    if (setup) begin
      s_next.prdata = 32'h0;
      s_next.pslverr = 1'b0;
      unique case (paddr)
        OFF_CTRL: s_next.prdata = {24'h0, s_reg.ctrl};
        OFF_STAT: s_next.prdata = {24'h0, s_reg.stat};
        OFF_TLVL: s_next.prdata = {27'h0, s_reg.tlvl};
        OFF_CMP0: s_next.prdata = {10'h0, s_reg.cmp0};
        OFF_CMP1: s_next.prdata = {10'h0, s_reg.cmp1};
        OFF_OPND: s_next.prdata = {10'h0, s_reg.opnd};
        OFF_INSTR: s_next.prdata = {10'h0, s_reg.instr};
        OFF_TPTR: s_next.prdata = 32'(s_reg.tptr);
        default: begin
          if (tbuf_hit(paddr)) begin
            s_next.prdata = {7'h0, s_reg.tbuf[paddr[PW+1:2]]};
          end else begin
            s_next.pslverr = 1'b1;
          end
        end
      endcase
    end
    // software writes first, so a hardware set below wins over a clear
    if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL: begin
          s_next.ctrl = pwdata[7:0] & CTRL_KEEP;
          if (pwdata[C_TCLR]) begin
            s_next.tptr = '0;
          end
          if (pwdata[C_START]) begin
            s_next.stat[S_PSTOP] = 1'b0; // [RQ2]
            s_next.ans.start = 1'b1; // [RQ2]
            s_next.ans.start_level = START_LEVEL; // [RQ2]
          end
        end
        OFF_STAT: s_next.stat = s_reg.stat & ~(pwdata[7:0] & STAT_W1C);
        OFF_TLVL: s_next.tlvl = pwdata[4:0]; // [RQ4]
        OFF_CMP0: s_next.cmp0 = pwdata[21:0];
        OFF_CMP1: s_next.cmp1 = pwdata[21:0];
        default: begin
        end
      endcase
    end
    if (br_take) begin
      s_next.tbuf[s_reg.tptr[PW-1:0]] = {cu_req.level, cu_req.iaddr}; // [RQ3]
      s_next.tptr = s_reg.tptr + 1'b1;
    end
    if (tfull) begin
      s_next.stat[S_TRACEI] = 1'b1; // [RQ3] [RQ5]
      s_next.stat[S_BTSTOP] = 1'b1; // [RQ5]
      s_next.stat[S_PSTOP] = 1'b1; // [RQ3] [RQ5]
    end
    if (ld_hit) begin
      s_next.opnd = cu_req.oaddr; // [RQ7]
      s_next.instr = cu_req.iaddr; // [RQ7]
      s_next.stat[S_CMPI] = 1'b1; // [RQ7]
      s_next.stat[S_M0] = 1'b1;
      if (s_reg.ctrl[C_CMP_STOP]) begin
        s_next.stat[S_PSTOP] = 1'b1; // [RQ6]
      end
    end
    // each fetch match overwrites the latch, so the later one remains
    if (f0_hit || f1_hit) begin
      s_next.instr = cu_req.iaddr; // [RQ10]
      s_next.stat[S_CMPI] = 1'b1; // [RQ10]
      if (f0_hit) begin
        s_next.stat[S_M0] = 1'b1;
      end
      if (f1_hit) begin
        s_next.stat[S_M1] = 1'b1; // [RQ10]
      end
      if (s_reg.ctrl[C_CMP_STOP]) begin
        s_next.stat[S_PSTOP] = 1'b1;
      end
    end
    if (io_wr) begin
      if (cu_req.io_reg == X_HIGH) begin
        s_next.stat[S_HIGH] = 1'b1; // [RQ1]
        s_next.stat[S_PSTOP] = 1'b1; // [RQ1]
      end else if (cu_req.io_reg == X_MASK) begin
        s_next.ans.mask = cu_req.io_wdata[7:0]; // [RQ9]
      end else if (cu_req.io_reg == X_UNMASK) begin
        s_next.ans.unmask = cu_req.io_wdata[7:0]; // [RQ9]
      end else if (cu_req.io_reg == X_LVLRST) begin
        s_next.ans.lvl_reset = 1'b1; // [RQ9]
      end else if (gpr_hit(cu_req.io_reg)) begin
        s_next.gpr[cu_req.io_reg[GW-1:0]] = cu_req.io_wdata; // [RQ8]
      end
    end
    if (io_rd) begin
      if (cu_req.io_reg == X_MASK) begin
        s_next.ans.io_rdata = {14'h0, s_reg.ans.mask};
      end else if (cu_req.io_reg == X_UNMASK) begin
        s_next.ans.io_rdata = {14'h0, s_reg.ans.unmask};
      end else if (gpr_hit(cu_req.io_reg)) begin
        s_next.ans.io_rdata = s_reg.gpr[cu_req.io_reg[GW-1:0]]; // [RQ8]
      end else begin
        s_next.ans.io_rdata = '0;
      end
    end
    s_next.ans.stop = s_next.stat[S_PSTOP];
    s_next.ans.high_irq = s_next.stat[S_HIGH]; // [RQ1]
    // low interrupt never drives the high line [RQ7]
    s_next.ans.low_irq = s_next.stat[S_TRACEI] || s_next.stat[S_CMPI];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.stat <= STAT_RST;
      s_reg.tlvl <= TLVL_RST;
      s_reg.ans.stop <= 1'b1;
      s_reg.ans.start_level <= START_LEVEL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign cu_ans = s_reg.ans;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence start_wr;
    wr_acc && paddr == OFF_CTRL && pwdata[C_START];
  endsequence
  sequence gpr_wr;
    io_wr && gpr_hit(cu_req.io_reg);
  endsequence
  sequence lvl_rst_op;
    io_wr && cu_req.io_reg == X_LVLRST;
  endsequence

  a_out70_high: assert property ( // [RQ1]
    io_wr && cu_req.io_reg == X_HIGH |=> cu_ans.high_irq && cu_ans.stop [*2])
    else $error("out x70 did not raise high interrupt");
  a_start_lvl1: assert property ( // [RQ2]
    start_wr ##0 !tfull && !ld_hit && !f0_hit && !f1_hit && !io_wr
    |=> cu_ans.start && cu_ans.start_level == START_LEVEL && !cu_ans.stop
    ##1 !cu_ans.start)
    else $error("start did not run at level 1");
  a_trace_full: assert property ( // [RQ3]
    tfull |=> cu_ans.stop && cu_ans.low_irq && s_reg.tptr == (PW+1)'(DEPTH))
    else $error("full trace buffer did not stop the unit");
  a_trace_gate: assert property ( // [RQ4]
    cu_req.branch && !traced(cu_req.level, s_reg.tlvl) && !wr_acc
    |=> $stable(s_reg.tptr))
    else $error("untraced level was recorded");
  a_status_a2: assert property ( // [RQ5]
    tfull && s_reg.stat == 8'h00 && !io_wr && !ld_hit && !f0_hit && !f1_hit && !wr_acc
    |=> s_reg.stat == STAT_TRACE_FULL && !cu_ans.high_irq)
    else $error("status word after trace stop is not xa2");
  a_load_stop: assert property ( // [RQ6]
    ld_hit && s_reg.ctrl[C_CMP_STOP] |=> cu_ans.stop)
    else $error("load compare did not stop the unit");
  a_cmp_latch: assert property ( // [RQ7]
    ld_hit && !f0_hit && !f1_hit && !s_reg.stat[S_HIGH] && !io_wr
    |=> s_reg.opnd == $past(cu_req.oaddr) && s_reg.instr == $past(cu_req.iaddr)
    && cu_ans.low_irq && !cu_ans.high_irq)
    else $error("compare hit latched wrong addresses");
  a_gpr_echo: assert property ( // [RQ8]
    gpr_wr ##1 (io_rd && cu_req.io_reg == $past(cu_req.io_reg))
    |=> cu_ans.io_rdata == $past(cu_req.io_wdata, 2))
    else $error("general register read back differs");
  a_mask_load: assert property ( // [RQ9]
    io_wr && cu_req.io_reg == X_MASK |=> cu_ans.mask == $past(cu_req.io_wdata[7:0]))
    else $error("mask output not loaded");
  a_fetch_two: assert property ( // [RQ10]
    f1_hit |=> s_reg.instr == $past(cu_req.iaddr) && s_reg.stat[S_M1] && s_reg.stat[S_CMPI])
    else $error("fetch compare bits or latch wrong");
  a_stop_stable: assert property ( // [RQ11]
    cu_ans.stop && !running && !wr_acc
    |=> $stable(s_reg.tbuf) && $stable(s_reg.opnd) && $stable(s_reg.instr)
    && $stable(s_reg.stat))
    else $error("captured state changed while stopped");
  a_unmask_load: assert property ( // [RQ9]
    io_wr && cu_req.io_reg == X_UNMASK |=> cu_ans.unmask == $past(cu_req.io_wdata[7:0]))
    else $error("unmask output not loaded");
  a_lvl_pulse: assert property ( // [RQ9]
    lvl_rst_op |=> cu_ans.lvl_reset)
    else $error("level reset pulse missing");
  a_lvl_quiet: assert property ( // [RQ9]
    !(io_wr && cu_req.io_reg == X_LVLRST) |=> !cu_ans.lvl_reset)
    else $error("level reset pulse without request");
  a_mask_read: assert property ( // [RQ9]
    io_rd && cu_req.io_reg == X_MASK |=> cu_ans.io_rdata == {14'h0, $past(cu_ans.mask)})
    else $error("mask read back differs");
endmodule : svc_debug

// [tb/cu_model.sv]
// Purpose: control unit stand-in driving the request carrier
// Assumes: same clock as the block, one event per pulse
// Notes: idle data lines toggle so a stale value is never trusted
`timescale 1ns/1ps
module cu_model
  import svc_debug_pkg::*;
(
  // clock
  input wire logic pclk,
  // request toward the block
  output cu_req_s cu_req
);
  initial cu_req = '0;

  task automatic pulse(input cu_req_s r);
    @(posedge pclk);
    cu_req <= r;
    @(posedge pclk);
    cu_req <= '{level: START_LEVEL, io_wdata: ~r.io_wdata, default: '0};
  endtask : pulse

  task automatic io(input logic wr, input logic [6:0] rg, input addr_t d);
    cu_req_s r;
    r = '0;
    r.io_op = 1'b1;
    r.io_write = wr;
    r.io_reg = rg;
    r.io_wdata = d;
    r.level = START_LEVEL;
    pulse(r);
  endtask : io

  // write then read of one register in adjacent cycles
  task automatic io_pair(input logic [6:0] rg, input addr_t d);
    cu_req_s r;
    r = '0;
    r.io_op = 1'b1;
    r.io_write = 1'b1;
    r.io_reg = rg;
    r.io_wdata = d;
    r.level = START_LEVEL;
    @(posedge pclk);
    cu_req <= r;
    r.io_write = 1'b0;
    r.io_wdata = ~d;
    pulse(r);
  endtask : io_pair

  task automatic mem(input logic ld, input addr_t ia, input addr_t oa);
    cu_req_s r;
    r = '0;
    r.fetch = !ld;
    r.load = ld;
    r.iaddr = ia;
    r.oaddr = oa;
    r.level = START_LEVEL;
    pulse(r);
  endtask : mem

  task automatic branches(input int n, input addr_t base);
    cu_req_s r;
    for (int i = 0; i < n; i++) begin
      r = '0;
      r.branch = 1'b1;
      r.level = 3'(i % 5 + 1);
      r.iaddr = base + addr_t'(i);
      @(posedge pclk);
      cu_req <= r;
    end
    @(posedge pclk);
    cu_req <= '{level: START_LEVEL, default: '0};
  endtask : branches
endmodule : cu_model

// [tb/test_svc_debug.sv]
// Purpose: self-checking bench for the service and debug block
// Assumes: zero-wait APB slave, control unit events one cycle apart
// Notes: pulses are counted by a monitor so none is missed
`timescale 1ns/1ps
module test_svc_debug
  import svc_debug_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cu_req_s cu_req;
  cu_ans_s cu_ans;
  int fail_count = 0;
  int check_count = 0;
  int starts = 0;
  int lvl_resets = 0;
  logic [31:0] rd;
  logic err;

  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (cu_ans.start === 1'b1) starts++;
    if (cu_ans.lvl_reset === 1'b1) lvl_resets++;
  end

  svc_debug #(.DEPTH(8), .NGPR(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cu_req(cu_req), .cu_ans(cu_ans));

  cu_model cu (.pclk(pclk), .cu_req(cu_req));

  task automatic complete_run();
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc

  task automatic t_reset();
    rchk("status", OFF_STAT, 32'h02);
    rchk("trace levels", OFF_TLVL, 32'h01);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("stop", 32'h1, 32'(cu_ans.stop));
  endtask : t_reset

  task automatic t_start();
    apb(1'b1, OFF_CTRL, 32'h1);
    cyc(2);
    chk("start pulses", 32'h1, 32'(starts));
    chk("stop", 32'h0, 32'(cu_ans.stop));
    chk("start level", 32'h1, 32'(cu_ans.start_level));
    rchk("status", OFF_STAT, 32'h00);
  endtask : t_start

  task automatic t_gpr();
    cu.io(1'b1, 7'h03, 22'h2aaaaa);
    cu.io(1'b1, 7'h05, 22'h155555);
    cu.io(1'b0, 7'h03, '0);
    cyc(2);
    chk("gpr3", 32'h2aaaaa, 32'(cu_ans.io_rdata));
    cu.io(1'b0, 7'h05, '0);
    cyc(2);
    chk("gpr5", 32'h155555, 32'(cu_ans.io_rdata));
    cu.io_pair(7'h06, 22'h3c0f0f);
    cyc(2);
    chk("gpr6 echo", 32'h3c0f0f, 32'(cu_ans.io_rdata));
    cu.io(1'b1, X_MASK, 22'h0000a5);
    cu.io(1'b1, X_UNMASK, 22'h00005a);
    cu.io(1'b1, X_LVLRST, '0);
    cyc(2);
    chk("mask", 32'ha5, 32'(cu_ans.mask));
    chk("unmask", 32'h5a, 32'(cu_ans.unmask));
    chk("level resets", 32'h1, 32'(lvl_resets));
    cu.io(1'b0, X_MASK, '0);
    cyc(2);
    chk("mask read", 32'ha5, 32'(cu_ans.io_rdata));
  endtask : t_gpr

  task automatic t_fetch();
    apb(1'b1, OFF_CMP0, 32'h100);
    apb(1'b1, OFF_CMP1, 32'h200);
    apb(1'b1, OFF_CTRL, 32'h08);
    cu.mem(1'b0, 22'h100, '0);
    cu.mem(1'b0, 22'h150, '0);
    cu.mem(1'b0, 22'h200, '0);
    cu.io(1'b1, X_HIGH, '0);
    cyc(2);
    chk("high irq", 32'h1, 32'(cu_ans.high_irq));
    chk("stop", 32'h1, 32'(cu_ans.stop));
    rchk("status", OFF_STAT, 32'h4f);
    rchk("instr latch", OFF_INSTR, 32'h200);
  endtask : t_fetch

  task automatic t_trace();
    apb(1'b1, OFF_STAT, 32'hff);
    apb(1'b1, OFF_TLVL, 32'h1b);
    apb(1'b1, OFF_CTRL, 32'h23);
    cyc(2);
    cu.branches(10, 22'h1000);
    cyc(2);
    chk("stop", 32'h1, 32'(cu_ans.stop));
    chk("low irq", 32'h1, 32'(cu_ans.low_irq));
    chk("high irq", 32'h0, 32'(cu_ans.high_irq));
    rchk("status", OFF_STAT, 32'ha2);
    rchk("entry2", 12'h048, 32'h01001003);
    rchk("entry7", 12'h05c, 32'h01401009);
    cu.branches(3, 22'h2000);
    cyc(2);
    rchk("pointer", OFF_TPTR, 32'h8);
    rchk("entry0", 12'h040, 32'h00401000);
  endtask : t_trace

  task automatic t_load();
    apb(1'b1, OFF_STAT, 32'hff);
    apb(1'b1, OFF_CMP0, 32'h12345);
    apb(1'b1, OFF_CTRL, 32'h15);
    cyc(2);
    cu.mem(1'b1, 22'h0abc, 22'h12344);
    cyc(1);
    chk("stop on miss", 32'h0, 32'(cu_ans.stop));
    cu.mem(1'b1, 22'h0abd, 22'h12345);
    cyc(2);
    chk("stop", 32'h1, 32'(cu_ans.stop));
    chk("low irq", 32'h1, 32'(cu_ans.low_irq));
    chk("high irq", 32'h0, 32'(cu_ans.high_irq));
    rchk("operand latch", OFF_OPND, 32'h12345);
    rchk("instr latch", OFF_INSTR, 32'habd);
  endtask : t_load

  // reset in mid-run, with the unit stopped and mask loaded
  task automatic t_rerun();
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    chk("stop in reset", 32'h1, 32'(cu_ans.stop));
    chk("mask in reset", 32'h0, 32'(cu_ans.mask));
    @(posedge pclk);
    presetn <= 1'b1;
    rchk("status", OFF_STAT, 32'h02);
    rchk("control", OFF_CTRL, 32'h00);
    rchk("pointer", OFF_TPTR, 32'h0);
    chk("unmask", 32'h0, 32'(cu_ans.unmask));
  endtask : t_rerun

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start();
    t_gpr();
    t_fetch();
    t_trace();
    t_load();
    t_rerun();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule : test_svc_debug
